// *** verilog/unvm_reader.v ***
// user nonvolatile memory: fabric byte read port and programming-side access
// Contract
// - The block holds 1 kbit of user storage that keeps its contents and can be reprogrammed.
// - For programming, the storage is eight banks of 128 bits each.
// - Reads return one byte per request on a synchronous port clocked by the fabric clock.
// - The 7-bit read address picks the bank by its top three bits and the byte by the low four.
// - Only the programming port can erase or write; fabric logic has no write path.
// - Contents are readable both from the programming port and from fabric addressing.
// - A programming load may ask for decryption, and the data is then decrypted before storing.
`timescale 1ns/1ps
`default_nettype none
`include "unvm_regs.vh"
module unvm_reader #(
  parameter BANKS = `UNVM_BANKS,
  parameter BANK_BITS = `UNVM_BANK_BITS
) (
  input wire clk,
  input wire rst,
  // fabric read port
  input wire rd_en,
  input wire [`UNVM_ADDR_W-1:0] rd_addr,
  output reg [7:0] rd_data,
  output reg rd_valid,
  // programming side, already deserialised from the test port
  input wire prog_erase,
  input wire prog_write,
  input wire prog_decrypt,
  input wire [2:0] prog_bank,
  input wire [BANK_BITS-1:0] prog_wdata,
  input wire prog_rd,
  input wire [2:0] prog_rd_bank,
  // external decryption engine request and answer, then programming readback and busy
  output reg dec_req,
  output reg [BANK_BITS-1:0] dec_in,
  input wire dec_done,
  input wire [BANK_BITS-1:0] dec_out,
  output reg [BANK_BITS-1:0] prog_rdata,
  output reg prog_busy
);
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  // the decrypt wait is internal only, so it has no shared code
  localparam [1:0] ST_IDLE = `UNVM_PROG_IDLE;
  localparam [1:0] ST_ERASE = `UNVM_PROG_ERASE;
  localparam [1:0] ST_WRITE = `UNVM_PROG_WRITE;
  localparam [1:0] ST_DECRYPT = 2'h3;
  localparam BYTE_W = 8;

  // ----------------------------------------------------------------
  // programming sequencer storage
  // ----------------------------------------------------------------
  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] bank_sel;
  reg [2:0] next_bank_sel;
  reg [BANK_BITS-1:0] wbuf;
  reg [BANK_BITS-1:0] next_wbuf;
  reg next_dec_req;
  reg [BANK_BITS-1:0] next_dec_in;
  reg next_prog_busy;
  wire [BANKS-1:0] bank_hit;
  wire [BANKS-1:0] erase_vec;
  wire [BANKS-1:0] write_vec;
  wire [BANK_BITS*BANKS-1:0] store;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // requests outside idle are dropped, not queued; erase wins over write
  wire seq_idle = (state == ST_IDLE);
  wire take_erase = seq_idle && prog_erase;
  wire take_write = seq_idle && prog_write && !prog_erase;
  wire take_plain = take_write && !prog_decrypt;
  wire take_cipher = take_write && prog_decrypt;

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  // plain loads take one cycle; decrypted loads wait for the engine
  // limitation: an engine that never answers holds the sequencer until reset
  always @* begin
    next_state = state;
    next_bank_sel = bank_sel;
    next_wbuf = wbuf;
    next_dec_req = 1'b0;
    next_dec_in = dec_in;
    next_prog_busy = prog_busy;
    case (state)
      ST_IDLE: begin
        if (take_erase) begin
          next_bank_sel = prog_bank;
          next_prog_busy = 1'b1;
          next_state = ST_ERASE;
        end
        if (take_plain) begin
          next_bank_sel = prog_bank;
          next_prog_busy = 1'b1;
          next_wbuf = prog_wdata;
          next_state = ST_WRITE;
        end
        if (take_cipher) begin
          next_bank_sel = prog_bank;
          next_prog_busy = 1'b1;
          next_dec_req = 1'b1;
          next_dec_in = prog_wdata;
          next_state = ST_DECRYPT;
        end
      end
      ST_ERASE: begin
        next_prog_busy = 1'b0;
        next_state = ST_IDLE;
      end
      ST_WRITE: begin
        next_prog_busy = 1'b0;
        next_state = ST_IDLE;
      end
      ST_DECRYPT: begin
        // only the decrypted word ever reaches the write buffer
        if (dec_done) begin
          next_wbuf = dec_out;
          next_state = ST_WRITE;
        end
      end
      default: begin
        next_prog_busy = 1'b0;
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bank_sel <= 3'h0;
      wbuf <= {BANK_BITS{1'b0}};
      dec_req <= 1'b0;
      dec_in <= {BANK_BITS{1'b0}};
      prog_busy <= 1'b0;
    end else begin
      state <= next_state;
      bank_sel <= next_bank_sel;
      wbuf <= next_wbuf;
      dec_req <= next_dec_req;
      dec_in <= next_dec_in;
      prog_busy <= next_prog_busy;
    end
  end

  // ----------------------------------------------------------------
  // banks: only the programming sequencer drives erase and write
  // ----------------------------------------------------------------
  // one-hot strobes; the fabric port has no way into these
  genvar g;
  generate
    for (g = 0; g < BANKS; g = g + 1) begin : g_bank
      assign bank_hit[g] = (bank_sel == g);
      assign erase_vec[g] = (state == ST_ERASE) && bank_hit[g];
      assign write_vec[g] = (state == ST_WRITE) && bank_hit[g];
      unvm_bank #(.WIDTH(BANK_BITS)) u_bank (
        .clk(clk),
        .erase(erase_vec[g]),
        .write(write_vec[g]),
        .wdata(wbuf),
        .data(store[g*BANK_BITS +: BANK_BITS])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // fabric read port
  // ----------------------------------------------------------------
  wire [2:0] rd_bank = rd_addr[`UNVM_BANK_MSB:`UNVM_BANK_LSB];
  wire [3:0] rd_byte = rd_addr[`UNVM_BYTE_MSB:`UNVM_BYTE_LSB];
  wire [BANK_BITS-1:0] rd_word = store[rd_bank*BANK_BITS +: BANK_BITS];
  reg [7:0] next_rd_data;
  reg next_rd_valid;

  // byte 0 is the low byte of the bank; one byte per request
  always @* begin
    next_rd_valid = rd_en;
    next_rd_data = rd_data;
    if (rd_en) begin
      next_rd_data = rd_word[rd_byte*BYTE_W +: BYTE_W];
    end
  end

  // address taken on this edge, byte shown until the next request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // ----------------------------------------------------------------
  // programming-side readback
  // ----------------------------------------------------------------
  reg [BANK_BITS-1:0] next_prog_rdata;

  // whole bank at once, matching the programming width
  always @* begin
    next_prog_rdata = prog_rdata;
    if (prog_rd) begin
      next_prog_rdata = store[prog_rd_bank*BANK_BITS +: BANK_BITS];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_rdata <= {BANK_BITS{1'b0}};
    end else begin
      prog_rdata <= next_prog_rdata;
    end
  end
endmodule // unvm_reader
`default_nettype wire

// *** verilog/unvm_regs.vh ***
// constants for the user nonvolatile memory byte reader
`ifndef UNVM_REGS_VH
`define UNVM_REGS_VH
`define UNVM_BANKS 8
`define UNVM_BANK_BITS 128
`define UNVM_BYTES_PER_BANK 16
`define UNVM_ADDR_W 7
`define UNVM_BANK_MSB 6
`define UNVM_BANK_LSB 4
`define UNVM_BYTE_MSB 3
`define UNVM_BYTE_LSB 0
`define UNVM_PROG_IDLE 2'h0
`define UNVM_PROG_ERASE 2'h1
`define UNVM_PROG_WRITE 2'h2
`define UNVM_ERASE_VALUE 128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF
`endif

// *** verilog/unvm_bank.v ***
// one 128-bit storage bank with erase and write from the programming side
`timescale 1ns/1ps
`default_nettype none
`include "unvm_regs.vh"
module unvm_bank #(
  parameter WIDTH = `UNVM_BANK_BITS
) (
  input wire clk,
  input wire erase,
  input wire write,
  input wire [WIDTH-1:0] wdata,
  output reg [WIDTH-1:0] data
);
  // storage is modelled as flops; reset does not clear it (nonvolatile)
  always @(posedge clk) begin
    if (erase) begin
      data <= `UNVM_ERASE_VALUE;
    end else if (write) begin
      data <= wdata;
    end
  end
endmodule // unvm_bank
`default_nettype wire

// *** tb/unvm_props.sv ***
// port checker for the user nvm byte reader
`timescale 1ns/1ps
`default_nettype none
module unvm_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_en,
  input wire logic rd_valid,
  input wire logic prog_erase,
  input wire logic prog_write,
  input wire logic prog_decrypt,
  input wire logic prog_busy,
  input wire logic dec_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire idle_wr = !prog_busy && prog_write && !prog_erase;
  sequence s_busy2; prog_busy ##1 !prog_busy; endsequence
  sequence s_pulse; dec_req ##1 !dec_req; endsequence
  property p_rd; rd_en |=> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read got no answer");
  property p_norv; !rd_en |=> !rd_valid; endproperty
  a_norv: assert property (p_norv) else $error("answer without request");
  property p_wr; idle_wr && !prog_decrypt |=> s_busy2; endproperty
  a_wr: assert property (p_wr) else $error("bank write busy span");
  property p_er; !prog_busy && prog_erase |=> s_busy2; endproperty
  a_er: assert property (p_er) else $error("erase busy span");
  property p_dec; idle_wr && prog_decrypt |=> s_pulse; endproperty
  a_dec: assert property (p_dec) else $error("no decrypt request");
  property p_decb; dec_req |-> prog_busy; endproperty
  a_decb: assert property (p_decb) else $error("decrypt request while not busy");
  property p_rdq; rd_en && !prog_busy && !prog_write && !prog_erase |=> !prog_busy; endproperty
  a_rdq: assert property (p_rdq) else $error("fabric read started programming");
endmodule // unvm_props
bind unvm_reader unvm_props u_props (
  .clk(clk),
  .rst(rst),
  .rd_en(rd_en),
  .rd_valid(rd_valid),
  .prog_erase(prog_erase),
  .prog_write(prog_write),
  .prog_decrypt(prog_decrypt),
  .prog_busy(prog_busy),
  .dec_req(dec_req)
);
`default_nettype wire

// *** tb/unvm_dec_model.sv ***
// decryption engine stand-in, answers after a set delay
`timescale 1ns/1ps
`default_nettype none
module unvm_dec_model #(parameter KEY = 128'h5A, parameter DLY = 3) (
  input wire logic clk,
  input wire logic dec_req,
  input wire logic [127:0] dec_in,
  output logic dec_done = 1'b0,
  output logic [127:0] dec_out = 128'h0
);
  logic [127:0] held;
  always @(posedge clk) if (dec_req) begin
    held <= dec_in ^ KEY;
    repeat (DLY) @(posedge clk);
    dec_done <= 1'b1;
    dec_out <= held;
    @(posedge clk);
    dec_done <= 1'b0;
    // stale plaintext must not look valid
    dec_out <= ~held;
  end
endmodule // unvm_dec_model
`default_nettype wire

// *** tb/unvm_reader_bench.sv ***
// bench for the user nvm byte reader
`timescale 1ns/1ps
`default_nettype none
module unvm_reader_bench;
  localparam [127:0] KEY = 128'h96000000000000000000000000000069;
  localparam [127:0] D = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  logic clk = 0, rst = 1, rd_en = 0, prog_erase = 0, prog_write = 0, prog_decrypt = 0;
  logic prog_rd = 0, dec_done, rd_valid, dec_req, prog_busy;
  logic [6:0] rd_addr = 7'h00;
  logic [2:0] prog_bank = 3'h0, prog_rd_bank = 3'h0;
  logic [127:0] prog_wdata = 128'h0, dec_in, dec_out, prog_rdata;
  logic [7:0] rd_data;
  int bad_count = 0, checks_done = 0;
  unvm_reader u_dut (
    .clk(clk),
    .rst(rst),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .prog_erase(prog_erase),
    .prog_write(prog_write),
    .prog_decrypt(prog_decrypt),
    .prog_bank(prog_bank),
    .prog_wdata(prog_wdata),
    .prog_rd(prog_rd),
    .prog_rd_bank(prog_rd_bank),
    .dec_req(dec_req),
    .dec_in(dec_in),
    .dec_done(dec_done),
    .dec_out(dec_out),
    .prog_rdata(prog_rdata),
    .prog_busy(prog_busy)
  );
  unvm_dec_model #(.KEY(KEY)) u_dec (
    .clk(clk),
    .dec_req(dec_req),
    .dec_in(dec_in),
    .dec_done(dec_done),
    .dec_out(dec_out)
  );
  always #4 clk = ~clk;
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic prog(input logic er, input logic dc, input logic [2:0] b, input logic [127:0] d);
    @(posedge clk);
    {prog_erase, prog_write, prog_decrypt, prog_bank, prog_wdata} <= {er, !er, dc, b, d};
    @(posedge clk);
    {prog_erase, prog_write} <= 2'h0;
    repeat (20) begin
      @(posedge clk);
      #1 if (!prog_busy) break;
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    {rd_en, rd_addr} <= {1'b1, a};
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_valid, 1'b1);
    chk(rd_data, e);
  endtask
  task automatic t_bytes;
    prog(1'b0, 1'b0, 3'h5, D);
    for (int n = 0; n < 16; n++) rd({3'h5, n[3:0]}, D[8*n +: 8]);
    // back-to-back requests, then the last byte must hold
    @(posedge clk);
    {rd_en, rd_addr} <= {1'b1, 7'h50};
    @(posedge clk);
    rd_addr <= 7'h51;
    #1 chk(rd_data, D[7:0]);
    chk(rd_valid, 1'b1);
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, D[15:8]);
    chk(rd_valid, 1'b1);
    @(posedge clk);
    #1 chk(rd_valid, 1'b0);
    chk(rd_data, D[15:8]);
    @(posedge clk);
    {prog_rd, prog_rd_bank} <= {1'b1, 3'h5};
    @(posedge clk);
    prog_rd <= 1'b0;
    #1 chk(prog_rdata, D);
  endtask
  task automatic t_erase;
    prog(1'b1, 1'b0, 3'h5, 128'h0);
    rd(7'h5F, 8'hFF);
  endtask
  task automatic t_dec;
    prog(1'b0, 1'b1, 3'h7, D);
    rd(7'h70, D[7:0] ^ KEY[7:0]);
    rd(7'h7F, D[127:120] ^ KEY[127:120]);
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 chk(rd_valid, 1'b0);
    chk(rd_data, 8'h00);
    chk(prog_busy, 1'b0);
    chk(prog_rdata, 128'h0);
    chk(dec_in, 128'h0);
    @(posedge clk);
    rst <= 1'b0;
    rd(7'h7F, D[127:120] ^ KEY[127:120]);
  endtask
  task automatic t_refuse;
    // a plain write while the decrypt load is pending must be dropped
    @(posedge clk);
    {prog_write, prog_decrypt, prog_bank, prog_wdata} <= {1'b1, 1'b1, 3'h2, D};
    @(posedge clk);
    {prog_decrypt, prog_wdata} <= {1'b0, ~D};
    @(posedge clk);
    prog_write <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1 if (!prog_busy) break;
    end
    rd(7'h20, D[7:0] ^ KEY[7:0]);
    // erase and write together: erase wins
    @(posedge clk);
    {prog_erase, prog_write, prog_bank} <= {1'b1, 1'b1, 3'h2};
    @(posedge clk);
    {prog_erase, prog_write} <= 2'h0;
    repeat (2) @(posedge clk);
    rd(7'h20, 8'hFF);
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_bytes();
    t_erase();
    t_dec();
    t_reset();
    t_refuse();
    give_verdict();
  end
  // whole run is some 90 cycles; the limit leaves ample margin
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule // unvm_reader_bench
`default_nettype wire
